// *** link_input_validity_monitor.sv ***
// Input validity monitor for cyclic link frames of several stations.
// Assumes frames come from link logic on the same clock, one frame a pulse.
`timescale 1ns/10ps
module link_input_validity_monitor
   import link_monitor_pkg::*;
#(
   parameter int NUM_STATIONS = 16,
   parameter int DATA_WORDS = 13,
   parameter int DELAY_DEPTH = 4
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Avalon-MM register slave
   input wire logic [link_monitor_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [link_monitor_pkg::REG_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [link_monitor_pkg::REG_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Received frames
   input wire logic frame_valid_in,
   input wire logic frame_ok_in,
   input wire logic [$clog2(NUM_STATIONS)-1:0] frame_station_in,
   input wire logic [link_monitor_pkg::WORD_W-1:0] frame_counter_in,
   input wire logic [link_monitor_pkg::WORD_W-1:0] frame_status_in,
   input wire logic [DATA_WORDS*link_monitor_pkg::WORD_W-1:0] frame_data_in,
   // Own high-speed scan
   input wire logic scan_tick_in,
   // Delayed commands and status
   output logic cmd_valid_out,
   output logic cmd_error_out,
   output logic [$clog2(NUM_STATIONS)-1:0] cmd_station_out,
   output logic [DATA_WORDS*link_monitor_pkg::WORD_W-1:0] cmd_data_out,
   output logic [link_monitor_pkg::WORD_W-1:0] tx_counter_out,
   output logic [NUM_STATIONS-1:0] io_error_out,
   output logic sync_state_out,
   output logic peer_fault_out,
   output logic irq_out
);
   import link_monitor_pkg::*;

   localparam int SW = $clog2(NUM_STATIONS);
   localparam int DW = DATA_WORDS * WORD_W;
   localparam int LW = 1 + SW + DW;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [CNT_W-1:0] upd_div;
      logic [CNT_W-1:0] chk_step;
      logic [15:0] scan_us;
      logic [15:0] link_us;
      logic [31:0] delay_cyc;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic irq;
      logic [31:0] in_err_cnt;
      logic [31:0] sts_err_cnt;
      logic [31:0] cnt_err_cnt;
      logic [NUM_STATIONS-1:0] io_err;
      logic [NUM_STATIONS-1:0] first_good;
      logic [NUM_STATIONS-1:0] prev_valid;
      logic [NUM_STATIONS-1:0][CNT_W-1:0] prev_cnt;
      logic [CNT_W-1:0] tx_cnt;
      logic [CNT_W-1:0] div_cnt;
      logic [CNT_W-1:0] last_rx;
      logic sync_state;
      logic peer_fault;
      logic sts_valid;
      logic wait_req;
      logic [REG_W-1:0] rdata;
   } mon_t;

   // Delay in cycles from scan period and link cycle, never below one
   function automatic logic [31:0] delay_cycles(input logic [15:0] scan_us,
                                                input logic [15:0] link_us);
      logic [31:0] us;
      logic [31:0] cyc;
      us = 32'(SCAN_FACTOR) * 32'(scan_us) + 32'(link_us);
      cyc = us * 32'(CYC_PER_US);
      return (cyc == 32'h0) ? 32'h1 : cyc;
   endfunction

   function automatic logic [REG_W-1:0] merge_be(input logic [REG_W-1:0] old,
                                                 input logic [REG_W-1:0] wdata,
                                                 input logic [3:0] be);
      logic [REG_W-1:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction

   localparam mon_t RST_ST = '{
      ctrl: CTRL_RST,
      upd_div: UPD_DIV_RST,
      chk_step: CHK_STEP_RST,
      scan_us: SCAN_US_RST,
      link_us: LINK_US_RST,
      delay_cyc: delay_cycles(SCAN_US_RST, LINK_US_RST),
      wait_req: 1'b1,
      default: '0
   };

   mon_t q;
   mon_t nxt_q;
   logic dly_valid;
   logic [LW-1:0] dly_data;
   logic dly_overrun;
   logic [LW-1:0] push_word;
   logic sts_ok_c;
   logic cnt_ok_c;
   logic good_c;
   logic st_ok_c;

   // Frame judgement, used by the state update and the checks below
   always_comb begin
      logic [CNT_W-1:0] expect_cnt;
      expect_cnt = q.prev_cnt[frame_station_in] + q.chk_step;
      st_ok_c = int'(frame_station_in) < NUM_STATIONS;
      sts_ok_c = !frame_status_in[WARNING_FLAG_BIT]
         && frame_status_in[COMMAND_ACCEPT_READY_BIT]
         && (!q.ctrl[CTRL_SYNC_BIT] || frame_status_in[SYNC_FLAG_BIT]);
      // Unchecked when disabled or before a reference value exists
      cnt_ok_c = !q.ctrl[CTRL_CHECK_BIT] || !q.prev_valid[frame_station_in]
         || frame_counter_in[CNT_W-1:0] == expect_cnt;
      good_c = frame_ok_in && sts_ok_c && cnt_ok_c;
      // Bad input is replaced by zero before anyone can use it
      push_word = {!good_c, frame_station_in, good_c ? frame_data_in : DW'(0)};
   end

   always_comb begin
      logic [IRQ_W-1:0] evt;
      logic [IRQ_W-1:0] clr;
      logic req;
      logic wr;
      logic [REG_W-1:0] rd;
      evt = '0;
      clr = '0;
      rd = '0;
      nxt_q = q;
      req = avs_read_in || avs_write_in;
      wr = avs_write_in && !q.wait_req;

      // Register read, answered one cycle after the request appears
      unique case (avs_address_in)
         CTRL_OFS: rd = REG_W'(q.ctrl);
         RATIO_OFS: rd = {16'h0, q.chk_step, q.upd_div};
         TIMING_OFS: rd = {q.link_us, q.scan_us};
         STATUS_OFS: rd = {28'h0, q.sts_valid, q.peer_fault, q.sync_state, |q.io_err};
         IRQ_STAT_OFS: rd = REG_W'(q.irq_stat);
         IRQ_EN_OFS: rd = REG_W'(q.irq_en);
         IN_ERR_OFS: rd = q.in_err_cnt;
         STS_ERR_OFS: rd = q.sts_err_cnt;
         CNT_ERR_OFS: rd = q.cnt_err_cnt;
         TX_CNT_OFS: rd = REG_W'(q.tx_cnt);
         RX_CNT_OFS: rd = REG_W'(q.last_rx);
         IO_ERR_OFS: rd = REG_W'(q.io_err);
         default: rd = '0;
      endcase
      nxt_q.wait_req = 1'b1;
      if (req && q.wait_req) begin
         nxt_q.wait_req = 1'b0;
         nxt_q.rdata = rd;
      end

      if (wr) begin
         unique case (avs_address_in)
            CTRL_OFS: begin
               nxt_q.ctrl = CTRL_W'(merge_be(REG_W'(q.ctrl), avs_writedata_in,
                                              avs_byteenable_in));
            end
            RATIO_OFS: begin
               {nxt_q.chk_step, nxt_q.upd_div} = 16'(merge_be(
                  {16'h0, q.chk_step, q.upd_div}, avs_writedata_in, avs_byteenable_in));
            end
            TIMING_OFS: begin
               {nxt_q.link_us, nxt_q.scan_us} = merge_be({q.link_us, q.scan_us},
                                                         avs_writedata_in, avs_byteenable_in);
            end
            IRQ_CLR_OFS: begin
               clr = IRQ_W'(merge_be('0, avs_writedata_in, avs_byteenable_in));
            end
            IRQ_EN_OFS: begin
               nxt_q.irq_en = IRQ_W'(merge_be(REG_W'(q.irq_en), avs_writedata_in,
                                              avs_byteenable_in));
            end
            default: begin
            end
         endcase
      end
      nxt_q.delay_cyc = delay_cycles(q.scan_us, q.link_us);

      // Own counter, advanced once every upd_div scans
      if (scan_tick_in && q.ctrl[CTRL_UPDATE_BIT]) begin
         if (q.div_cnt + 8'h1 >= q.upd_div) begin
            nxt_q.div_cnt = '0;
            nxt_q.tx_cnt = q.tx_cnt + 8'h1;
         end else begin
            nxt_q.div_cnt = q.div_cnt + 8'h1;
         end
      end

      if (frame_valid_in && st_ok_c) begin
         if (frame_ok_in) begin
            nxt_q.prev_cnt[frame_station_in] = frame_counter_in[CNT_W-1:0];
            nxt_q.prev_valid[frame_station_in] = 1'b1;
            nxt_q.last_rx = frame_counter_in[CNT_W-1:0];
            nxt_q.sync_state = frame_status_in[SYNC_FLAG_BIT];
            nxt_q.sts_valid = sts_ok_c;
            nxt_q.peer_fault = !cnt_ok_c;
            if (!sts_ok_c) begin
               nxt_q.sts_err_cnt = q.sts_err_cnt + 32'h1;
               evt[IRQ_STATUS_BIT] = 1'b1;
            end
            if (!cnt_ok_c) begin
               nxt_q.cnt_err_cnt = q.cnt_err_cnt + 32'h1;
               evt[IRQ_COUNTER_BIT] = 1'b1;
            end
         end
         if (good_c) begin
            nxt_q.first_good[frame_station_in] = 1'b1;
            nxt_q.io_err[frame_station_in] = 1'b0;
            evt[IRQ_RECOVER_BIT] = q.io_err[frame_station_in];
         end else begin
            nxt_q.in_err_cnt = q.in_err_cnt + 32'h1;
            evt[IRQ_INPUT_BIT] = 1'b1;
            // Unconnected since power-up leaves the bit clear
            if (q.first_good[frame_station_in]) begin
               nxt_q.io_err[frame_station_in] = 1'b1;
            end
         end
      end
      evt[IRQ_OVERRUN_BIT] = dly_overrun;

      // A new event beats a clear in the same cycle
      nxt_q.irq_stat = (q.irq_stat & ~clr) | evt;
      nxt_q.irq = |(nxt_q.irq_stat & nxt_q.irq_en);
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= RST_ST;
      end else begin
         q <= nxt_q;
      end
   end

   // Every frame with an in-range station is pushed, so good and bad keep the same latency
   fixed_delay_line #(
      .W(LW),
      .DEPTH(DELAY_DEPTH)
   ) u_delay (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .push_in(frame_valid_in && st_ok_c),
      .push_data_in(push_word),
      .delay_in(q.delay_cyc),
      .pop_valid_out(dly_valid),
      .pop_data_out(dly_data),
      .overrun_out(dly_overrun)
   );

   assign cmd_valid_out = dly_valid;
   assign cmd_error_out = dly_data[LW-1];
   assign cmd_station_out = dly_data[DW +: SW];
   assign cmd_data_out = dly_data[DW-1:0];
   assign tx_counter_out = {8'h00, q.tx_cnt};
   assign io_error_out = q.io_err;
   assign sync_state_out = q.sync_state;
   assign peer_fault_out = q.peer_fault;
   assign irq_out = q.irq;
   assign avs_readdata_out = q.rdata;
   assign avs_waitrequest_out = q.wait_req;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence good_frame_s;
      frame_valid_in && st_ok_c && good_c;
   endsequence

   sequence bad_status_s;
      frame_valid_in && st_ok_c && frame_ok_in && !sts_ok_c;
   endsequence

   zero_on_error_a: assert property (
      cmd_valid_out && cmd_error_out |-> cmd_data_out == '0)
      else $error("Errored input passed with nonzero data");

   status_count_a: assert property (
      bad_status_s |=> q.sts_err_cnt == $past(q.sts_err_cnt) + 32'h1)
      else $error("Status error not counted");

   status_rule_a: assert property (
      frame_valid_in && frame_ok_in && st_ok_c && frame_status_in[WARNING_FLAG_BIT]
      |=> !q.sts_valid)
      else $error("Warning flag accepted as valid status");

   counter_error_a: assert property (
      frame_valid_in && st_ok_c && frame_ok_in && q.ctrl[CTRL_CHECK_BIT]
      && q.prev_valid[frame_station_in]
      && frame_counter_in[7:0] != 8'(q.prev_cnt[frame_station_in] + q.chk_step)
      |=> q.cnt_err_cnt == $past(q.cnt_err_cnt) + 32'h1 && q.peer_fault)
      else $error("Counter miss not counted");

   input_count_a: assert property (
      frame_valid_in && st_ok_c && !frame_ok_in
      |=> q.in_err_cnt == $past(q.in_err_cnt) + 32'h1)
      else $error("Input error not counted");

   good_first_a: assert property (
      (io_error_out & ~q.first_good) == '0)
      else $error("Error bit set before any good input");

   auto_recover_a: assert property (
      good_frame_s |=> !io_error_out[$past(frame_station_in)])
      else $error("Error bit stuck after good input");

   tx_advance_a: assert property (
      scan_tick_in && q.ctrl[CTRL_UPDATE_BIT] && q.upd_div == 8'h1
      |=> tx_counter_out[7:0] == 8'($past(tx_counter_out[7:0]) + 8'h1))
      else $error("Own counter did not advance");

   bus_answer_a: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("Bus answer not one cycle long");
endmodule

// *** link_monitor_pkg.sv ***
// Shared constants for the link input validity monitor.
// Assumes a 100 MHz clock and a 32-bit Avalon-MM register bus.
package link_monitor_pkg;
   localparam int ADDR_W = 8;
   localparam int REG_W = 32;
   localparam int WORD_W = 16;
   localparam int CNT_W = 8;
   localparam int IRQ_W = 5;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] RATIO_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] TIMING_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] IN_ERR_OFS = 8'h1c;
   localparam logic [ADDR_W-1:0] STS_ERR_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] CNT_ERR_OFS = 8'h24;
   localparam logic [ADDR_W-1:0] TX_CNT_OFS = 8'h28;
   localparam logic [ADDR_W-1:0] RX_CNT_OFS = 8'h2c;
   localparam logic [ADDR_W-1:0] IO_ERR_OFS = 8'h30;

   // Control field positions
   localparam int CTRL_SYNC_BIT = 0;
   localparam int CTRL_CHECK_BIT = 1;
   localparam int CTRL_UPDATE_BIT = 2;
   localparam int CTRL_W = 3;

   // Received slave status word
   localparam int WARNING_FLAG_BIT = 1;
   localparam int COMMAND_ACCEPT_READY_BIT = 2;
   localparam int SYNC_FLAG_BIT = 7;

   // Interrupt status bits
   localparam int IRQ_INPUT_BIT = 0;
   localparam int IRQ_STATUS_BIT = 1;
   localparam int IRQ_COUNTER_BIT = 2;
   localparam int IRQ_RECOVER_BIT = 3;
   localparam int IRQ_OVERRUN_BIT = 4;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
   localparam logic [CNT_W-1:0] UPD_DIV_RST = 8'h01;
   localparam logic [CNT_W-1:0] CHK_STEP_RST = 8'h01;
   localparam logic [15:0] SCAN_US_RST = 16'h0fa0;
   localparam logic [15:0] LINK_US_RST = 16'h03e8;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
   localparam int SCAN_FACTOR = 2;
endpackage

// *** fixed_delay_line.sv ***
// Fixed-latency delay line: every pushed word not dropped as overrun leaves exactly delay_in
// cycles later. Assumes delay_in >= 1 and held steady while words are in flight.
`timescale 1ns/10ps
module fixed_delay_line #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Push side
   input wire logic push_in,
   input wire logic [W-1:0] push_data_in,
   input wire logic [31:0] delay_in,
   // Release side
   output logic pop_valid_out,
   output logic [W-1:0] pop_data_out,
   output logic overrun_out
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [31:0] now;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [PW:0] count;
      logic [DEPTH-1:0][31:0] due;
      logic [DEPTH-1:0][W-1:0] mem;
      logic out_valid;
      logic [W-1:0] out_data;
      logic overrun;
   } line_t;

   line_t q;
   line_t nxt_q;
   logic [31:0] age_ff;

   always_comb begin
      logic pop;
      logic take;
      pop = 1'b0;
      take = 1'b0;
      nxt_q = q;
      nxt_q.now = q.now + 32'h1;
      nxt_q.out_valid = 1'b0;
      nxt_q.overrun = 1'b0;
      // Head leaves one cycle early so the output flop lands on the exact cycle
      if (q.count != '0 && q.due[q.rd] == q.now) begin
         pop = 1'b1;
         nxt_q.out_valid = 1'b1;
         nxt_q.out_data = q.mem[q.rd];
         nxt_q.rd = PW'(q.rd + 1'b1);
      end
      if (push_in) begin
         if (delay_in == 32'h1) begin
            // Shortest delay skips the queue, which stays empty while delay_in is steady
            nxt_q.out_valid = 1'b1;
            nxt_q.out_data = push_data_in;
         end else if (q.count == (PW + 1)'(DEPTH) && !pop) begin
            nxt_q.overrun = 1'b1;
         end else begin
            take = 1'b1;
            nxt_q.due[q.wr] = q.now + delay_in - 32'h1;
            nxt_q.mem[q.wr] = push_data_in;
            nxt_q.wr = PW'(q.wr + 1'b1);
         end
      end
      nxt_q.count = q.count + (PW + 1)'(take) - (PW + 1)'(pop);
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= nxt_q;
      end
   end

   assign pop_valid_out = q.out_valid;
   assign pop_data_out = q.out_data;
   assign overrun_out = q.overrun;

   // Cycles since the last accepted push, for the latency check only
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         age_ff <= 32'h0;
      end else if (push_in && !nxt_q.overrun) begin
         age_ff <= 32'h1;
      end else if (age_ff != 32'hffff_ffff) begin
         age_ff <= age_ff + 32'h1;
      end
   end

   fixed_latency_a: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      (q.out_valid && q.count == '0 && !$past(push_in)) |-> age_ff == delay_in)
      else $error("Delayed word left at the wrong cycle");
endmodule

// *** link_master_model.sv ***
// Behavioural model of the link master that sends cyclic frames to the monitor.
// Assumes the monitor samples every frame field on the rising edge of clock_in.
`timescale 1ns/10ps
module link_master_model #(
   parameter int ST_W = 2,
   parameter int DW = 32
) (
   // Clock
   input wire logic clock_in,
   // Frame towards the monitor
   output logic frame_valid_out,
   output logic frame_ok_out,
   output logic [ST_W-1:0] station_out,
   output logic [15:0] counter_out,
   output logic [15:0] status_out,
   output logic [DW-1:0] data_out
);
   initial begin
      frame_valid_out = 1'b0;
      frame_ok_out = 1'b0;
      station_out = '0;
      counter_out = 16'h0000;
      status_out = 16'h0000;
      data_out = '0;
   end
   // Caller advances cnt once per scan and wraps at 8 bits
   // Status word is built by the caller a frozen counter is legal
   task automatic send(input logic [ST_W-1:0] st, input logic ok, input logic [7:0] cnt,
         input logic [15:0] sts, input logic [DW-1:0] d);
      @(posedge clock_in);
      frame_valid_out <= 1'b1;
      frame_ok_out <= ok;
      station_out <= st;
      counter_out <= {8'h00, cnt};
      status_out <= sts;
      data_out <= d;
      @(posedge clock_in);
      frame_valid_out <= 1'b0;
      // Stale fields flip so the monitor cannot lean on them
      frame_ok_out <= ~ok;
      station_out <= ~st;
      counter_out <= ~{8'h00, cnt};
      status_out <= ~sts;
      data_out <= ~d;
   endtask
endmodule

// *** link_input_validity_monitor_tb_top.sv ***
// Self-checking bench: link master model, register bus tasks, queue model.
// Assumes a 100 MHz clock; TIMING is shortened so the fixed delay is 300 cycles.
`timescale 1ns/10ps
module link_input_validity_monitor_tb_top;
   import link_monitor_pkg::*;
   localparam int NS = 4;
   localparam int DW = 2 * WORD_W;
   localparam int DLY = 300;
   localparam logic [15:0] GOOD = 16'h0084;
   logic clock_in, rstn_in, rd, wr, scan_tick, f_valid, f_ok, wait_req;
   logic c_valid, c_err, sync_st, p_fault, irq;
   logic [ADDR_W-1:0] addr;
   logic [REG_W-1:0] wdata, rdata, got;
   logic [1:0] f_st, c_st;
   logic [15:0] f_cnt, f_sts, tx_cnt;
   logic [DW-1:0] f_data, c_data;
   logic [NS-1:0] io_err;
   logic [31:0] rs = 32'h44a021a7;
   logic [15:0] bad[3] = '{16'h0086, 16'h0080, 16'h0004};
   int err_total, check_count, cyc, m_in, m_sts, m_cnt, step, i;
   int prev[NS];
   bit has_prev[NS], good_seen[NS], io_m[NS];
   bit sync_mode, check_on;
   int tq[$];
   logic eq_err[$];
   logic [1:0] eq_st[$];
   logic [DW-1:0] eq_d[$];

   link_input_validity_monitor #(.NUM_STATIONS(NS), .DATA_WORDS(2), .DELAY_DEPTH(32))
   link_input_validity_monitor_i (
      .clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .frame_valid_in(f_valid),
      .frame_ok_in(f_ok), .frame_station_in(f_st), .frame_counter_in(f_cnt),
      .frame_status_in(f_sts), .frame_data_in(f_data), .scan_tick_in(scan_tick),
      .cmd_valid_out(c_valid), .cmd_error_out(c_err), .cmd_station_out(c_st),
      .cmd_data_out(c_data), .tx_counter_out(tx_cnt), .io_error_out(io_err),
      .sync_state_out(sync_st), .peer_fault_out(p_fault), .irq_out(irq));

   link_master_model #(.ST_W(2), .DW(DW)) link_master_model_i (
      .clock_in(clock_in), .frame_valid_out(f_valid), .frame_ok_out(f_ok),
      .station_out(f_st), .counter_out(f_cnt), .status_out(f_sts), .data_out(f_data));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Holds the request until waitrequest is sampled low, whatever the latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      // Only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clock_in);
      end while (wait_req !== 1'b0);
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(got, e);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clock_in);
         scan_tick <= 1'b1;
         @(posedge clock_in);
         scan_tick <= 1'b0;
      end
      repeat (3) @(posedge clock_in);
   endtask

   task automatic send_frame(input logic [1:0] st, input logic ok, input logic [7:0] cnt,
         input logic [15:0] sts);
      logic vld, cf, e;
      logic [DW-1:0] d;
      d = xs();
      vld = !sts[1] && sts[2] && (!sync_mode || sts[7]);
      cf = check_on && has_prev[st] && cnt != 8'(prev[st] + step);
      e = !ok || !vld || cf;
      m_in += int'(e);
      if (ok) begin
         m_sts += int'(!vld);
         m_cnt += int'(cf);
         prev[st] = cnt;
         has_prev[st] = 1;
      end
      if (e && good_seen[st]) io_m[st] = 1;
      if (!e) begin
         io_m[st] = 0;
         good_seen[st] = 1;
      end
      eq_err.push_back(e);
      eq_st.push_back(st);
      eq_d.push_back(e ? '0 : d);
      link_master_model_i.send(st, ok, cnt, sts, d);
      repeat (2) @(posedge clock_in);
      chk(io_err[st], io_m[st]);
      if (ok) chk(p_fault, cf);
      if (ok) chk(sync_st, sts[7]);
   endtask

   always @(posedge clock_in) begin
      cyc++;
      if (f_valid === 1'b1) tq.push_back(cyc);
      if (c_valid === 1'b1) begin
         if (eq_err.size() == 0) chk(1, 0);
         else begin
            chk(cyc - tq.pop_front(), DLY);
            chk(c_err, eq_err.pop_front());
            chk(c_st, eq_st.pop_front());
            chk(c_data, eq_d.pop_front());
         end
      end
   end

   initial begin
      repeat (5000) @(posedge clock_in);
      err_total++;
      report_and_stop();
   end

   initial begin
      rstn_in = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = '0;
      wdata = '0;
      scan_tick = 1'b0;
      step = 1;
      sync_mode = 1;
      check_on = 1;
      repeat (5) @(posedge clock_in);
      rstn_in <= 1'b1;
      @(posedge clock_in);
      chk(wait_req, 1'b1);
      rd_chk(CTRL_OFS, 32'h0);
      rd_chk(RATIO_OFS, 32'h0101);
      rd_chk(TIMING_OFS, 32'h03e8_0fa0);
      rd_chk(8'h3c, 32'h0);
      $display("test reset done");
      bus(1'b1, TIMING_OFS, 32'h0001_0001);
      bus(1'b1, CTRL_OFS, 32'h7);
      bus(1'b1, IRQ_EN_OFS, 32'h1f);
      send_frame(2'd1, 1'b0, 8'h00, GOOD);
      for (i = 0; i < 5; i++) send_frame(2'd1, 1'b1, 8'(8'hfc + i), GOOD);
      for (i = 0; i < 3; i++) send_frame(2'd1, 1'b1, 8'(1 + i), bad[i]);
      send_frame(2'd1, 1'b1, 8'h04, GOOD);
      send_frame(2'd1, 1'b1, 8'h06, GOOD);
      send_frame(2'd2, 1'b0, 8'h00, GOOD);
      $display("test frames done");
      chk(irq, 1'b1);
      bus(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(got[2:0], 3'h7);
      bus(1'b1, IRQ_CLR_OFS, 32'h1f);
      repeat (2) @(posedge clock_in);
      chk(irq, 1'b0);
      bus(1'b1, IRQ_EN_OFS, 32'h0);
      send_frame(2'd1, 1'b0, 8'h00, GOOD);
      chk(irq, 1'b0);
      bus(1'b1, IRQ_EN_OFS, 32'h1);
      repeat (2) @(posedge clock_in);
      chk(irq, 1'b1);
      bus(1'b1, IRQ_CLR_OFS, 32'h1f);
      $display("test irq done");
      ticks(5);
      chk(tx_cnt, 16'h0005);
      bus(1'b1, RATIO_OFS, 32'h0202);
      step = 2;
      ticks(4);
      chk(tx_cnt, 16'h0007);
      bus(1'b1, CTRL_OFS, 32'h6);
      sync_mode = 0;
      send_frame(2'd1, 1'b1, 8'h08, 16'h0004);
      bus(1'b1, CTRL_OFS, 32'h4);
      check_on = 0;
      send_frame(2'd1, 1'b1, 8'h08, GOOD);
      $display("test modes done");
      // Every frame still in flight must emerge before the counts are read
      repeat (DLY + 10) @(posedge clock_in);
      chk(eq_err.size(), 0);
      rd_chk(IN_ERR_OFS, m_in);
      rd_chk(STS_ERR_OFS, m_sts);
      rd_chk(CNT_ERR_OFS, m_cnt);
      $display("test counters done");
      report_and_stop();
   end
endmodule
